/* File: logic/swcfg_regs.v */
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "swcfg_consts.vh"

module swcfg_regs #(
  parameter ADDR_W = 18
) (
  input wire clk,
  input wire rst,
  // Avalon-MM slave, byte addressed
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Demodulator status
  input wire sync_detect,
  input wire sync_is_secondary,
  input wire frame_delimiter_flag,
  input wire [7:0] offset_raw,
  input wire offset_raw_valid,
  // Demodulator settings
  output wire [31:0] primary_pattern,
  output wire [31:0] secondary_sync_pattern,
  output reg [31:0] primary_tx_order,
  output reg [31:0] secondary_tx_order,
  output wire dual_search_en,
  output wire pattern_bit_order,
  output wire [1:0] offset_filter_mode,
  output wire [5:0] sync_len_bits,
  output wire [31:0] sync_len_mask,
  output wire sync_len_reserved,
  output wire offset_comp_en,
  output wire offset_double_decay,
  output wire [7:0] carrier_offset_value,
  output wire matched_word_flag
);

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait state on every access: read data is registered in the
  // first cycle and presented while waitrequest is low.
  reg ack_r;
  wire req;
  wire wr_go;
  wire [15:0] word_idx;
  wire wr_lane0;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_go = avs_write & ack_r;
  assign word_idx = avs_address[17:2];
  assign wr_lane0 = wr_go & avs_byteenable[0] & (avs_address[1:0] == 2'h0);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ----------------------------------------
  // Sync search configuration
  // ----------------------------------------
  reg dual_r;
  reg rsvd_r;
  reg [4:0] len_code_r;
  reg match_r;
  wire cfg_hit;
  wire [7:0] cfg_rd;
  localparam [7:0] CFG_RST = `SWCFG_RST_SEARCH_CFG;

  assign cfg_hit = (word_idx == `SWCFG_IDX_SEARCH_CFG);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dual_r <= CFG_RST[`SWCFG_DUAL_BIT];
      rsvd_r <= CFG_RST[`SWCFG_RSVD_BIT];
      len_code_r <= CFG_RST[`SWCFG_LEN_MSB:`SWCFG_LEN_LSB];
    end else if (wr_lane0 && cfg_hit) begin
      dual_r <= avs_writedata[`SWCFG_DUAL_BIT];
      // Stored as written; software keeps it zero
      rsvd_r <= avs_writedata[`SWCFG_RSVD_BIT];
      len_code_r <= avs_writedata[`SWCFG_LEN_MSB:`SWCFG_LEN_LSB];
    end
  end

  assign dual_search_en = dual_r;

  // ----------------------------------------
  // Matched-word flag
  // ----------------------------------------
  // A secondary hit is impossible with dual search off, so it is masked
  // to keep a stray status strobe from reporting one.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      match_r <= 1'b0;
    end else if (sync_detect) begin
      match_r <= sync_is_secondary & dual_r;
    end
  end

  // Only meaningful while the frame delimiter is up; software must
  // qualify it with the radio status register.
  assign matched_word_flag = match_r;

  assign cfg_rd = {dual_r, rsvd_r, match_r, len_code_r};

  // ----------------------------------------
  // Pattern byte registers
  // ----------------------------------------
  wire [7:0] pat_byte [0:7];
  wire [7:0] pat_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pat
      localparam integer IDX_INT = (gi < 4) ? (`SWCFG_IDX_PRIM_B0 + gi) :
                                              (`SWCFG_IDX_SEC_B0 + (gi - 4));
      localparam [15:0] IDX = IDX_INT[15:0];
      reg [7:0] byte_r;
      assign pat_hit[gi] = (word_idx == IDX);
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          byte_r <= `SWCFG_RST_PATTERN;
        end else if (wr_lane0 && pat_hit[gi]) begin
          byte_r <= avs_writedata[7:0];
        end
      end
      assign pat_byte[gi] = byte_r;
    end
  endgenerate

  // Lowest address holds the lowest pattern byte
  assign primary_pattern = {pat_byte[3], pat_byte[2], pat_byte[1], pat_byte[0]};
  assign secondary_sync_pattern =
    {pat_byte[7], pat_byte[6], pat_byte[5], pat_byte[4]};

  // ----------------------------------------
  // Demodulator control (filter mode, bit order)
  // ----------------------------------------
  reg [1:0] mode_r;
  reg order_r;
  wire ctrl_hit;
  wire stat_hit;
  wire est_hit;

  assign ctrl_hit = (word_idx == `SWCFG_IDX_DEMOD_CTRL);
  assign stat_hit = (word_idx == `SWCFG_IDX_RADIO_STATUS);
  assign est_hit = (word_idx == `SWCFG_IDX_OFFSET_EST);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= `SWCFG_RST_MODE;
      order_r <= `SWCFG_RST_ORDER;
    end else if (wr_lane0 && ctrl_hit) begin
      mode_r <= avs_writedata[`SWCFG_MODE_MSB:`SWCFG_MODE_LSB];
      order_r <= avs_writedata[`SWCFG_ORDER_BIT];
    end
  end

  assign offset_filter_mode = mode_r;
  assign pattern_bit_order = order_r;

  // ----------------------------------------
  // Patterns in line order
  // ----------------------------------------
  // Bit 0 of each output is the first bit on air. Registered so the
  // correlator never sees a half-swapped word after an order change.
  wire [31:0] prim_ord_nxt;
  wire [31:0] sec_ord_nxt;

  genvar bi;
  generate
    for (bi = 0; bi < 32; bi = bi + 1) begin : g_order
      assign prim_ord_nxt[bi] = order_r ? primary_pattern[31-bi] :
                                          primary_pattern[bi];
      assign sec_ord_nxt[bi] = order_r ? secondary_sync_pattern[31-bi] :
                                         secondary_sync_pattern[bi];
    end
  endgenerate

  // One process drives both words and is the only driver of each output register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      primary_tx_order <= 32'h00000000;
      secondary_tx_order <= 32'h00000000;
    end else begin
      primary_tx_order <= prim_ord_nxt;
      secondary_tx_order <= sec_ord_nxt;
    end
  end

  // ----------------------------------------
  // Length decode and offset estimate
  // ----------------------------------------
  swcfg_len_decode swcfg_len_decode_inst (
    .clk(clk),
    .rst(rst),
    .len_code(len_code_r),
    .len_bits(sync_len_bits),
    .len_mask(sync_len_mask),
    .len_reserved(sync_len_reserved)
  );

  swcfg_offset_hold swcfg_offset_hold_inst (
    .clk(clk),
    .rst(rst),
    .mode(mode_r),
    .frame_delimiter_flag(frame_delimiter_flag),
    .offset_raw(offset_raw),
    .offset_raw_valid(offset_raw_valid),
    .carrier_offset_value(carrier_offset_value),
    .offset_comp_en(offset_comp_en),
    .offset_double_decay(offset_double_decay)
  );

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  // Unmapped or misaligned reads return zero; writes there are dropped.
  reg [7:0] rd_byte;
  integer ri;

  always @* begin
    rd_byte = 8'h00;
    if (cfg_hit) begin
      rd_byte = cfg_rd;
    end else if (est_hit) begin
      rd_byte = carrier_offset_value;
    end else if (ctrl_hit) begin
      rd_byte = {5'h00, order_r, mode_r};
    end else if (stat_hit) begin
      rd_byte = {7'h00, frame_delimiter_flag};
    end else begin
      for (ri = 0; ri < 8; ri = ri + 1) begin
        if (pat_hit[ri]) begin
          rd_byte = pat_byte[ri];
        end
      end
    end
    if (avs_address[1:0] != 2'h0) begin
      rd_byte = 8'h00;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

endmodule // swcfg_regs
`default_nettype wire

/* File: shared/swcfg_consts.vh */
// What this block does
// - Dual-search enable at bit 7 clear hunts the primary pattern only; set hunts both patterns.
// - The read-only matched-word flag at bit 5 is 0 for a primary match, 1 for a secondary one.
// - The matched-word flag only means something while the frame-delimiter flag is 1.
// - The five-bit length code in bits 4:0 sets the pattern bits matched; code 0 0000 means 32.
// - The primary pattern is four byte registers at indices 0x6195 to 0x6198, lowest byte first.
// - The secondary pattern is four byte registers at indices 0x61f8 to 0x61fb, lowest byte first.
// - The offset register is read-only and shows an eight-bit two's-complement carrier offset.
// - When the offset register refreshes is set by the offset filter mode field.
// - Filter mode 00 no compensation, 01 freeze after sync, 10 continuous, 11 freeze, double decay.
// - Pattern bit order 0 sends and expects the pattern LSB first, 1 MSB first.
`ifndef SWCFG_CONSTS_VH
`define SWCFG_CONSTS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define SWCFG_IDX_SEARCH_CFG 16'h6194
`define SWCFG_IDX_PRIM_B0 16'h6195
`define SWCFG_IDX_PRIM_B1 16'h6196
`define SWCFG_IDX_PRIM_B2 16'h6197
`define SWCFG_IDX_PRIM_B3 16'h6198
`define SWCFG_IDX_OFFSET_EST 16'h6199
`define SWCFG_IDX_SEC_B0 16'h61f8
`define SWCFG_IDX_SEC_B1 16'h61f9
`define SWCFG_IDX_SEC_B2 16'h61fa
`define SWCFG_IDX_SEC_B3 16'h61fb
`define SWCFG_IDX_DEMOD_CTRL 16'h6200
`define SWCFG_IDX_RADIO_STATUS 16'h6201

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SWCFG_DUAL_BIT 7
`define SWCFG_RSVD_BIT 6
`define SWCFG_MATCH_BIT 5
`define SWCFG_LEN_MSB 4
`define SWCFG_LEN_LSB 0
`define SWCFG_MODE_MSB 1
`define SWCFG_MODE_LSB 0
`define SWCFG_ORDER_BIT 2
`define SWCFG_FDF_BIT 0

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define SWCFG_RST_SEARCH_CFG 8'h00
`define SWCFG_RST_PATTERN 8'h00
`define SWCFG_RST_OFFSET 8'h00
`define SWCFG_RST_MODE 2'h1
`define SWCFG_RST_ORDER 1'h0
`define SWCFG_MODE_NONE 2'h0
`define SWCFG_MODE_FREEZE 2'h1
`define SWCFG_MODE_CONT 2'h2
`define SWCFG_MODE_FREEZE_DD 2'h3
`define SWCFG_LEN_FULL_BITS 6'h20
`define SWCFG_LEN_BASE_BITS 6'h10

`endif

/* File: logic/swcfg_len_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "swcfg_consts.vh"

module swcfg_len_decode (
  input wire clk,
  input wire rst,
  input wire [4:0] len_code,
  output reg [5:0] len_bits,
  output reg [31:0] len_mask,
  output reg len_reserved
);

  reg [5:0] bits_nxt;
  reg rsvd_nxt;
  integer k;
  reg [31:0] mask_nxt;

  always @* begin
    bits_nxt = `SWCFG_LEN_FULL_BITS;
    rsvd_nxt = 1'b0;
    mask_nxt = 32'h00000000;
    if (len_code[4]) begin
      bits_nxt = `SWCFG_LEN_BASE_BITS + {2'h0, len_code[3:0]};
    end else if (len_code[3:0] != 4'h0) begin
      // Reserved codes fall back to full length
      rsvd_nxt = 1'b1;
    end
    for (k = 0; k < 32; k = k + 1) begin
      mask_nxt[k] = (k < bits_nxt);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      len_bits <= `SWCFG_LEN_FULL_BITS;
      len_mask <= 32'hffffffff;
      len_reserved <= 1'b0;
    end else begin
      len_bits <= bits_nxt;
      len_mask <= mask_nxt;
      len_reserved <= rsvd_nxt;
    end
  end

endmodule // swcfg_len_decode
`default_nettype wire

/* File: logic/swcfg_offset_hold.v */
`timescale 1ns/1ps
`default_nettype none
`include "swcfg_consts.vh"

module swcfg_offset_hold (
  input wire clk,
  input wire rst,
  input wire [1:0] mode,
  input wire frame_delimiter_flag,
  input wire [7:0] offset_raw,
  input wire offset_raw_valid,
  output reg [7:0] carrier_offset_value,
  output reg offset_comp_en,
  output reg offset_double_decay
);

  reg freeze;

  always @* begin
    case (mode)
      `SWCFG_MODE_FREEZE: freeze = frame_delimiter_flag;
      `SWCFG_MODE_FREEZE_DD: freeze = frame_delimiter_flag;
      default: freeze = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      carrier_offset_value <= `SWCFG_RST_OFFSET;
      offset_comp_en <= 1'b0;
      offset_double_decay <= 1'b0;
    end else begin
      if (offset_raw_valid && !freeze) begin
        carrier_offset_value <= offset_raw;
      end
      offset_comp_en <= (mode != `SWCFG_MODE_NONE);
      offset_double_decay <= (mode == `SWCFG_MODE_FREEZE_DD);
    end
  end

endmodule // swcfg_offset_hold
`default_nettype wire

/* File: dv/swcfg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module swcfg_monitor (
  input wire clk,
  input wire rst,
  input wire sync_detect,
  input wire sync_is_secondary,
  input wire frame_delimiter_flag,
  input wire [7:0] offset_raw,
  input wire offset_raw_valid,
  input wire dual_search_en,
  input wire [1:0] offset_filter_mode,
  input wire [5:0] sync_len_bits,
  input wire [31:0] sync_len_mask,
  input wire offset_comp_en,
  input wire offset_double_decay,
  input wire [7:0] carrier_offset_value,
  input wire matched_word_flag
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Estimate is held only while a frame is on air
  wire frz = frame_delimiter_flag && offset_filter_mode[0];
  a_flag_load: assert property (
    sync_detect |=> matched_word_flag == $past(sync_is_secondary && dual_search_en))
    else $error("flag load");
  a_flag_primary: assert property (
    sync_detect && !dual_search_en |=> !matched_word_flag) else $error("dual off");
  a_flag_hold: assert property (
    !sync_detect |=> $stable(matched_word_flag)) else $error("flag hold");
  a_len_mask: assert property (
    sync_len_mask == ~(32'hffffffff << sync_len_bits)) else $error("len mask");
  a_len_range: assert property (
    sync_len_bits >= 6'h10 && sync_len_bits <= 6'h20) else $error("len range");
  a_off_freeze: assert property (
    offset_raw_valid && frz |=> $stable(carrier_offset_value)) else $error("freeze");
  a_off_track: assert property (
    offset_raw_valid && !frz |=> carrier_offset_value == $past(offset_raw)) else $error("track");
  a_mode_flags: assert property (
    !rst |=> offset_comp_en == ($past(offset_filter_mode) != 2'h0) &&
      offset_double_decay == ($past(offset_filter_mode) == 2'h3)) else $error("mode");
endmodule // swcfg_monitor
bind swcfg_regs swcfg_monitor swcfg_monitor_inst (.clk, .rst, .sync_detect, .sync_is_secondary,
  .frame_delimiter_flag, .offset_raw, .offset_raw_valid, .dual_search_en, .offset_filter_mode,
  .sync_len_bits, .sync_len_mask, .offset_comp_en, .offset_double_decay, .carrier_offset_value,
  .matched_word_flag);
`default_nettype wire

/* File: dv/sync_word_config_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "swcfg_consts.vh"
module sync_word_config_regs_tb_top;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, sync_detect, sync_is_secondary;
  logic frame_delimiter_flag, offset_raw_valid, dual_search_en, pattern_bit_order;
  logic sync_len_reserved, offset_comp_en, offset_double_decay, matched_word_flag;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, primary_pattern, secondary_sync_pattern;
  logic [31:0] primary_tx_order, secondary_tx_order, sync_len_mask;
  logic [3:0] avs_byteenable;
  logic [7:0] offset_raw, carrier_offset_value;
  logic [5:0] sync_len_bits;
  logic [1:0] offset_filter_mode;
  logic [4:0] codes [7] = '{5'h00, 5'h01, 5'h0f, 5'h10, 5'h13, 5'h1f, 5'h05};
  int n_fail = 0;
  int n_checks = 0;
  swcfg_regs swcfg_regs_inst (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .sync_detect, .sync_is_secondary,
    .frame_delimiter_flag, .offset_raw, .offset_raw_valid, .primary_pattern,
    .secondary_sync_pattern, .primary_tx_order, .secondary_tx_order, .dual_search_en,
    .pattern_bit_order, .offset_filter_mode, .sync_len_bits, .sync_len_mask, .sync_len_reserved,
    .offset_comp_en, .offset_double_decay, .carrier_offset_value, .matched_word_flag);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Reads are compared against e; waits for the answer, never a fixed count
  task automatic rw(input logic w, input logic [15:0] i, input logic [7:0] d, input logic [31:0] e);
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    repeat (20) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (avs_waitrequest !== 1'b0) n_fail++;
    if (!w) chk(avs_readdata, e);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic pulse(input logic sd, input logic sec, input logic ov, input logic [7:0] v);
    @(posedge clk);
    sync_detect <= sd;
    sync_is_secondary <= sec;
    offset_raw_valid <= ov;
    offset_raw <= v;
    @(posedge clk);
    sync_detect <= 1'b0;
    sync_is_secondary <= ~sec;
    offset_raw_valid <= 1'b0;
    offset_raw <= ~v;
    @(posedge clk);
  endtask
  task automatic t_pattern;
    rw(1'b0, 16'h6195, 8'h0, 32'h0);
    rw(1'b0, `SWCFG_IDX_DEMOD_CTRL, 8'h0, 32'h1);
    for (int k = 0; k < 4; k++) begin
      rw(1'b1, 16'h6195 + 16'(k), 8'h11 * 8'(k + 1), 32'h0);
      rw(1'b1, 16'h61f8 + 16'(k), 8'h55 + 8'h11 * 8'(k), 32'h0);
    end
    rw(1'b1, 16'h6100, 8'h5a, 32'h0);
    rw(1'b0, 16'h6100, 8'h0, 32'h0);
    rw(1'b1, `SWCFG_IDX_OFFSET_EST, 8'h5a, 32'h0);
    rw(1'b0, `SWCFG_IDX_OFFSET_EST, 8'h0, 32'h0);
    rw(1'b0, 16'h61fa, 8'h0, 32'h77);
    chk(primary_pattern, 32'h44332211);
    chk(secondary_sync_pattern, 32'h88776655);
    chk(primary_tx_order, 32'h44332211);
    chk(secondary_tx_order, 32'h88776655);
    rw(1'b1, `SWCFG_IDX_DEMOD_CTRL, 8'h05, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(pattern_bit_order), 32'h1);
    chk(primary_tx_order, 32'h8844cc22);
    chk(secondary_tx_order, 32'haa66ee11);
  endtask
  task automatic t_length;
    logic [5:0] b;
    for (int i = 0; i < 7; i++) begin
      rw(1'b1, `SWCFG_IDX_SEARCH_CFG, {3'h0, codes[i]}, 32'h0);
      repeat (2) @(posedge clk);
      b = codes[i][4] ? 6'h10 + 6'(codes[i][3:0]) : 6'h20;
      chk(32'(sync_len_bits), 32'(b));
      chk(sync_len_mask, ~(32'hffffffff << b));
      chk(32'(sync_len_reserved), 32'(codes[i] != 5'h0 && !codes[i][4]));
    end
  endtask
  task automatic t_match;
    frame_delimiter_flag <= 1'b1;
    pulse(1'b1, 1'b1, 1'b0, 8'h0);
    chk(32'(matched_word_flag), 32'h0);
    rw(1'b1, `SWCFG_IDX_SEARCH_CFG, 8'h80, 32'h0);
    pulse(1'b1, 1'b1, 1'b0, 8'h0);
    chk(32'(matched_word_flag), 32'h1);
    rw(1'b0, `SWCFG_IDX_SEARCH_CFG, 8'h0, 32'ha0);
    rw(1'b0, `SWCFG_IDX_RADIO_STATUS, 8'h0, 32'h1);
    pulse(1'b1, 1'b0, 1'b0, 8'h0);
    chk(32'(matched_word_flag), 32'h0);
    chk(32'(dual_search_en), 32'h1);
    frame_delimiter_flag <= 1'b0;
    rw(1'b0, `SWCFG_IDX_RADIO_STATUS, 8'h0, 32'h0);
  endtask
  // Last pass is a freeze mode outside a frame, which must still track
  task automatic t_offset;
    logic [7:0] est;
    logic [1:0] m;
    est = 8'h0;
    for (int i = 0; i < 5; i++) begin
      m = (i == 4) ? 2'h1 : 2'(i);
      frame_delimiter_flag <= (i != 4);
      rw(1'b1, `SWCFG_IDX_DEMOD_CTRL, {6'h0, m}, 32'h0);
      pulse(1'b0, 1'b0, 1'b1, 8'h80 + 8'(i));
      if (!(m[0] && i < 4)) est = 8'h80 + 8'(i);
      chk(32'(carrier_offset_value), 32'(est));
      chk(32'(offset_filter_mode), 32'(m));
      rw(1'b0, `SWCFG_IDX_OFFSET_EST, 8'h0, 32'(est));
      chk(32'({offset_double_decay, offset_comp_en}), 32'({m == 2'h3, m != 2'h0}));
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, sync_detect, sync_is_secondary} = 4'h0;
    {frame_delimiter_flag, offset_raw_valid, offset_raw} = 10'h0;
    avs_address = 18'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_pattern;
    t_length;
    t_match;
    t_offset;
    tally_and_finish;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
endmodule // sync_word_config_regs_tb_top
`default_nettype wire
